// ---- logic/tcs_map.vh ----
`ifndef TCS_MAP_VH
`define TCS_MAP_VH
// Strap level codes
`define TCS_LVL_0 2'h0
`define TCS_LVL_R 2'h1
`define TCS_LVL_F 2'h2
`define TCS_LVL_1 2'h3
// Configuration codes {display, usb}
`define TCS_CFG_PD 2'h0
`define TCS_CFG_USB 2'h1
`define TCS_CFG_DP4 2'h2
`define TCS_CFG_DPU 2'h3
// Timing figures
`define TCS_CLK_MHZ 20
`define TCS_IDLE_ENTRY_NS 10
`define TCS_U1_EXIT_NS 6
`define TCS_U23_EXIT_US 10
`define TCS_RXDET_INT_MS 12
`define TCS_SHTDN_EXIT_MS 1
`define TCS_PWRUP_MS 1
`define TCS_AUX_OPEN_MS 2
`define TCS_DEBOUNCE_MS 3
`define TCS_STRAP_HOLD_US 10
// AUX snoop addresses and values
`define TCS_DPCD_LANE_COUNT 20'h00101
`define TCS_DPCD_POWER 20'h00600
`define TCS_PWR_D3 3'h2
`endif

// ---- logic/tcs_debounce.v ----
`timescale 1ns/1ps
`default_nettype none
module tcs_debounce #(
    parameter integer FALL_CYCLES = 60000
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Raw and filtered level
    input wire raw_i,
    output reg level_o
);
    reg [31:0] count;

    // Rise passes at once, fall must persist
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
            count <= 32'h0;
        end else if (raw_i) begin
            level_o <= 1'b1;
            count <= 32'h0;
        end else if (level_o) begin
            if (count >= FALL_CYCLES - 1) begin
                level_o <= 1'b0;
                count <= 32'h0;
            end else begin
                count <= count + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/tcs_delay.v ----
`timescale 1ns/1ps
`default_nettype none
module tcs_delay #(
    parameter integer CYCLES = 1
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Level and its delayed rise
    input wire start_i,
    output reg done_o
);
    reg [31:0] count;

    // Done once start has stayed high for CYCLES
    always @(posedge clk_sys_i) begin
        if (!rst_n_i || !start_i) begin
            count <= 32'h0;
            done_o <= 1'b0;
        end else if (count >= CYCLES - 1) begin
            done_o <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ---- logic/tcs_switch_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.vh"
module tcs_switch_ctrl #(
    parameter integer IDLE_ENTRY_CYC = (`TCS_IDLE_ENTRY_NS * `TCS_CLK_MHZ + 999) / 1000,
    parameter integer U1_EXIT_CYC = (`TCS_U1_EXIT_NS * `TCS_CLK_MHZ + 999) / 1000,
    parameter integer U23_EXIT_CYC = `TCS_U23_EXIT_US * `TCS_CLK_MHZ,
    parameter integer RXDET_CYC = `TCS_RXDET_INT_MS * 1000 * `TCS_CLK_MHZ,
    parameter integer SHTDN_CYC = `TCS_SHTDN_EXIT_MS * 1000 * `TCS_CLK_MHZ,
    parameter integer PWRUP_CYC = `TCS_PWRUP_MS * 1000 * `TCS_CLK_MHZ,
    parameter integer AUX_OPEN_CYC = `TCS_AUX_OPEN_MS * 1000 * `TCS_CLK_MHZ,
    parameter integer DEBOUNCE_CYC = `TCS_DEBOUNCE_MS * 1000 * `TCS_CLK_MHZ,
    parameter integer STRAP_HOLD_CYC = `TCS_STRAP_HOLD_US * `TCS_CLK_MHZ
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Control pins
    input wire usb_enable_pin_i,
    input wire usb_enable_mid_i,
    input wire display_enable_pin_i,
    input wire flip_pin_i,
    input wire hot_plug_input_i,
    // Straps, two-bit decoded levels
    input wire [1:0] host_mode_strap_i,
    input wire [3:0] usb_down_eq_straps_i,
    input wire [3:0] usb_up_eq_straps_i,
    input wire [3:0] display_eq_straps_i,
    // Register-mode controls
    input wire [1:0] cfg_sel_i,
    input wire flip_sel_i,
    input wire snoop_disable_i,
    input wire [3:0] dp_lane_en_reg_i,
    input wire eq_override_i,
    input wire [3:0] usb_down_eq_field_a_i,
    input wire [3:0] usb_down_eq_field_b_i,
    input wire [3:0] usb_up_eq_field_i,
    input wire [3:0] display_eq_field_i,
    // AUX snoop write strobe
    input wire aux_wr_i,
    input wire [19:0] aux_addr_i,
    input wire [7:0] aux_data_i,
    // USB physical conditions
    input wire far_rx_present_i,
    input wire rx_idle_i,
    input wire lfps_i,
    input wire ss_rate_i,
    // Status
    output reg device_active_o,
    output reg pin_mode_o,
    output reg strap_pulls_on_o,
    output reg [1:0] cfg_o,
    output reg flip_o,
    output reg [3:0] usb_state_o,
    // USB and display datapath control
    output reg rx_term_en_o,
    output reg rx_detect_o,
    output reg tx_idle_o,
    output reg lfps_fwd_o,
    output reg [3:0] usb_down_eq_o,
    output reg [3:0] usb_up_eq_o,
    output reg [3:0] display_eq_o,
    output reg [3:0] dp_lane_en_o,
    // Crosspoint: source for DP0..3 and SS pair, 0=TX1 1=RX1 2=TX2 3=RX2
    output reg [7:0] dp_route_o,
    output reg [1:0] ssrx_src_o,
    output reg sstx_to_tx2_o,
    output reg usb_path_en_o,
    // AUX/SBU switch: 0 open, 1 straight, 2 swapped
    output reg [1:0] aux_map_o
);
    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_DISC = 5'h02;
    localparam [4:0] ST_U23 = 5'h04;
    localparam [4:0] ST_U1 = 5'h08;
    localparam [4:0] ST_U0 = 5'h10;

    reg [4:0] state;
    reg [4:0] next_state;
    reg [31:0] tmr;
    reg [31:0] pwr_cnt;
    reg [31:0] hold_cnt;
    reg straps_taken;
    reg [1:0] host_lvl;
    reg [3:0] dn_strap;
    reg [3:0] up_strap;
    reg [3:0] dp_strap;
    reg usb_forced;
    reg usb_pin_q;
    reg usb_seen_high;
    reg [2:0] snoop_lanes;
    reg snoop_d3;
    reg [1:0] next_cfg;
    reg next_flip;
    reg [3:0] next_lanes;
    wire dp_en_db;
    wire hpd_db;
    wire dp_low_long;
    wire mid_done;
    wire usb_on;

    // One-, two- or four-lane mask from a lane count
    function [3:0] lane_mask;
        input [2:0] n;
        begin
            case (n)
                3'h1: lane_mask = 4'h1;
                3'h2: lane_mask = 4'h3;
                3'h4: lane_mask = 4'hf;
                default: lane_mask = 4'h0;
            endcase
        end
    endfunction

    // Debounced falls of display enable and hot plug
    tcs_debounce #(.FALL_CYCLES(DEBOUNCE_CYC)) u_db_dp (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i(display_enable_pin_i),
        .level_o(dp_en_db)
    );
    tcs_debounce #(.FALL_CYCLES(DEBOUNCE_CYC)) u_db_hpd (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i(hot_plug_input_i),
        .level_o(hpd_db)
    );

    // Display enable low long enough to open AUX
    tcs_delay #(.CYCLES(AUX_OPEN_CYC)) u_aux_open (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(!dp_en_db),
        .done_o(dp_low_long)
    );

    // Shutdown exit on mid-level usb enable
    tcs_delay #(.CYCLES(SHTDN_CYC)) u_shtdn (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(usb_enable_mid_i),
        .done_o(mid_done)
    );

    // Strap capture at once, pull release and power-up to active after their counts
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pwr_cnt <= 32'h0;
            device_active_o <= 1'b0;
            hold_cnt <= 32'h0;
            straps_taken <= 1'b0;
            strap_pulls_on_o <= 1'b1;
            host_lvl <= `TCS_LVL_0;
            dn_strap <= 4'h0;
            up_strap <= 4'h0;
            dp_strap <= 4'h0;
            pin_mode_o <= 1'b1;
        end else begin
            if (!straps_taken) begin
                straps_taken <= 1'b1;
                host_lvl <= host_mode_strap_i;
                dn_strap <= usb_down_eq_straps_i;
                up_strap <= usb_up_eq_straps_i;
                dp_strap <= display_eq_straps_i;
                pin_mode_o <= (host_mode_strap_i == `TCS_LVL_0);
            end
            if (strap_pulls_on_o) begin
                if (hold_cnt >= STRAP_HOLD_CYC - 1) begin
                    strap_pulls_on_o <= 1'b0;
                end else begin
                    hold_cnt <= hold_cnt + 32'h1;
                end
            end
            if (!device_active_o) begin
                if (pwr_cnt >= PWRUP_CYC - 1) begin
                    device_active_o <= 1'b1;
                end else begin
                    pwr_cnt <= pwr_cnt + 32'h1;
                end
            end
        end
    end

    // USB-only until a low-high-low pulse on usb enable or a high display enable
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            usb_forced <= 1'b1;
            usb_pin_q <= 1'b0;
            usb_seen_high <= 1'b0;
        end else begin
            usb_pin_q <= usb_enable_pin_i;
            if (usb_enable_pin_i && !usb_pin_q) usb_seen_high <= 1'b1;
            if (usb_forced && ((usb_seen_high && !usb_enable_pin_i)
                               || display_enable_pin_i || !pin_mode_o)) begin
                usb_forced <= 1'b0;
            end
        end
    end

    // Configuration selection
    always @* begin
        next_cfg = `TCS_CFG_USB;
        next_flip = flip_pin_i;
        if (!pin_mode_o) begin
            next_cfg = cfg_sel_i;
            next_flip = flip_sel_i;
        end else if (!usb_forced) begin
            next_cfg = {dp_en_db, usb_enable_pin_i | usb_enable_mid_i};
        end
    end

    // Snooped lane count and sink power state
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            snoop_lanes <= 3'h4;
            snoop_d3 <= 1'b0;
        end else if (aux_wr_i && !pin_mode_o && !snoop_disable_i && cfg_o[1]) begin
            if (aux_addr_i == `TCS_DPCD_LANE_COUNT) snoop_lanes <= aux_data_i[2:0];
            if (aux_addr_i == `TCS_DPCD_POWER) begin
                snoop_d3 <= (aux_data_i[2:0] == `TCS_PWR_D3);
            end
        end
    end

    // Display lane enables
    always @* begin
        next_lanes = 4'h0;
        if (cfg_o[1] && hpd_db) begin
            if (pin_mode_o) next_lanes = 4'hf;
            else if (snoop_disable_i) next_lanes = dp_lane_en_reg_i;
            else if (!snoop_d3) next_lanes = lane_mask(snoop_lanes);
            if (cfg_o[0]) next_lanes = next_lanes & 4'h3; // Two lanes beside USB
        end
    end

    assign usb_on = cfg_o[0] && device_active_o;

    // USB link power state tracker
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (usb_on && !usb_enable_mid_i) next_state = ST_DISC;
                if (usb_enable_mid_i && mid_done) next_state = ST_U23;
            end
            ST_DISC: begin
                if (far_rx_present_i) next_state = ST_U23;
            end
            ST_U23: begin
                if (!far_rx_present_i) next_state = ST_DISC;
                else if (!rx_idle_i && ss_rate_i) next_state = ST_U0;
            end
            ST_U1: begin
                if (!far_rx_present_i) next_state = ST_DISC;
                else if (!rx_idle_i && ss_rate_i) next_state = ST_U0;
                else if (tmr >= U23_EXIT_CYC) next_state = ST_U23;
            end
            ST_U0: begin
                if (!far_rx_present_i) next_state = ST_DISC;
                else if (rx_idle_i || lfps_i) next_state = ST_U1;
            end
            default: next_state = ST_OFF;
        endcase
        if (!usb_on && !usb_enable_mid_i) next_state = ST_OFF;
    end

    // Tracker state, timer and USB datapath outputs
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= ST_OFF;
            tmr <= 32'h0;
            rx_detect_o <= 1'b0;
            rx_term_en_o <= 1'b0;
            tx_idle_o <= 1'b1;
            lfps_fwd_o <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= (state == ST_DISC || !rx_idle_i) ? tmr + 32'h1 : 32'h0;
            if (next_state != state) tmr <= 32'h0;
            rx_detect_o <= 1'b0;
            if (state == ST_DISC && (tmr == 32'h0 || tmr >= RXDET_CYC - 1)) begin
                rx_detect_o <= 1'b1;
                tmr <= 32'h1;
            end
            rx_term_en_o <= (next_state == ST_U23 || next_state == ST_U1
                             || next_state == ST_U0);
            if (state == ST_U0) begin
                tx_idle_o <= (rx_idle_i && tmr >= IDLE_ENTRY_CYC - 1);
            end else begin
                tx_idle_o <= (state != ST_U1 && state != ST_U23) || rx_idle_i;
            end
            lfps_fwd_o <= 1'b0;
            if (!rx_idle_i && ((state == ST_U1 && tmr >= U1_EXIT_CYC - 1)
                               || (state == ST_U23 && tmr >= U23_EXIT_CYC - 1))) begin
                lfps_fwd_o <= 1'b1;
            end
        end
    end

    // Configuration, equalization, lanes, routing, AUX map
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cfg_o <= `TCS_CFG_USB;
            flip_o <= 1'b0;
            usb_state_o <= 4'h0;
            usb_down_eq_o <= 4'h0;
            usb_up_eq_o <= 4'h0;
            display_eq_o <= 4'h0;
            dp_lane_en_o <= 4'h0;
            dp_route_o <= 8'h00;
            ssrx_src_o <= 2'h1;
            sstx_to_tx2_o <= 1'b0;
            usb_path_en_o <= 1'b0;
            aux_map_o <= 2'h0;
        end else begin
            cfg_o <= next_cfg;
            flip_o <= next_flip;
            usb_state_o <= state[4:1];
            dp_lane_en_o <= next_lanes;
            usb_down_eq_o <= eq_override_i ? (flip_o ? usb_down_eq_field_b_i
                                                     : usb_down_eq_field_a_i) : dn_strap;
            usb_up_eq_o <= eq_override_i ? usb_up_eq_field_i : up_strap;
            display_eq_o <= eq_override_i ? display_eq_field_i : dp_strap;
            if (lfps_i) begin
                usb_down_eq_o <= 4'h0;
                usb_up_eq_o <= 4'h0;
            end
            usb_path_en_o <= cfg_o[0];
            ssrx_src_o <= flip_o ? 2'h3 : 2'h1;
            sstx_to_tx2_o <= flip_o;
            case (cfg_o)
                `TCS_CFG_DP4: dp_route_o <= flip_o ? 8'hb4 : 8'h1e;
                `TCS_CFG_DPU: dp_route_o <= flip_o ? 8'h04 : 8'h0e;
                default: dp_route_o <= 8'h00;
            endcase
            if (cfg_o[1]) aux_map_o <= flip_o ? 2'h2 : 2'h1;
            else if (dp_low_long || !pin_mode_o) aux_map_o <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/tcs_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_ctrl_checker #(
    parameter integer STRAP_HOLD_CYC = 20,
    parameter integer PWRUP_CYC = 20,
    parameter integer RXDET_CYC = 50
) (
    // Clock, reset and watched inputs
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [1:0] host_mode_strap_i,
    input wire logic lfps_i,
    // Watched outputs
    input wire logic device_active_o,
    input wire logic pin_mode_o,
    input wire logic strap_pulls_on_o,
    input wire logic [1:0] cfg_o,
    input wire logic flip_o,
    input wire logic [3:0] usb_state_o,
    input wire logic rx_detect_o,
    input wire logic tx_idle_o,
    input wire logic [3:0] usb_up_eq_o,
    input wire logic [3:0] dp_lane_en_o,
    input wire logic [1:0] aux_map_o
);
    logic [15:0] since_rst;
    logic [15:0] disc_cnt;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Cycles since reset release and since the last receiver detect
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            since_rst <= 16'h0;
            disc_cnt <= 16'h0;
        end else begin
            if (since_rst != 16'hffff) since_rst <= since_rst + 16'h1;
            if (usb_state_o == 4'h1 && !rx_detect_o) disc_cnt <= disc_cnt + 16'h1;
            else disc_cnt <= 16'h0;
        end
    end

    strap_sample_a: assert property (
        $rose(rst_n_i) |=> pin_mode_o == ($past(host_mode_strap_i) == 2'h0))
        else $error("pin mode differs from sampled host strap");
    pulls_release_a: assert property (
        since_rst > STRAP_HOLD_CYC + 2 |-> !strap_pulls_on_o)
        else $error("strap pulls still connected");
    active_in_time_a: assert property (
        since_rst > PWRUP_CYC + 2 |-> device_active_o)
        else $error("device not active in time");
    rxdet_interval_a: assert property (
        disc_cnt <= RXDET_CYC)
        else $error("receiver detect interval too long");
    idle_entry_a: assert property (
        $fell(usb_state_o[3]) |-> ##[0:1] tx_idle_o)
        else $error("no electrical idle after leaving active state");
    lfps_bypass_a: assert property (
        lfps_i [*2] |-> usb_up_eq_o == 4'h0)
        else $error("equalization applied during low frequency signalling");
    lanes_need_dp_a: assert property (
        (!cfg_o[1]) [*3] |-> dp_lane_en_o == 4'h0)
        else $error("display lane on without display configuration");
    aux_straight_a: assert property (
        (cfg_o[1] && !flip_o) [*2] |-> aux_map_o == 2'h1)
        else $error("sideband switch not straight");

    // Main scenarios reached
    cover property (usb_state_o == 4'h8);
    cover property ($fell(strap_pulls_on_o));
    cover property (aux_map_o == 2'h2);
endmodule

bind tcs_switch_ctrl tcs_ctrl_checker #(
    .STRAP_HOLD_CYC(STRAP_HOLD_CYC),
    .PWRUP_CYC(PWRUP_CYC),
    .RXDET_CYC(RXDET_CYC)
) chk_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_mode_strap_i(host_mode_strap_i),
    .lfps_i(lfps_i), .device_active_o(device_active_o), .pin_mode_o(pin_mode_o),
    .strap_pulls_on_o(strap_pulls_on_o), .cfg_o(cfg_o), .flip_o(flip_o),
    .usb_state_o(usb_state_o), .rx_detect_o(rx_detect_o), .tx_idle_o(tx_idle_o),
    .usb_up_eq_o(usb_up_eq_o), .dp_lane_en_o(dp_lane_en_o), .aux_map_o(aux_map_o)
);
`default_nettype wire

// ---- dv/tcs_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_far_side (
    // Clock
    input wire logic clk_sys_i,
    // Link conditions seen at the receivers
    output logic far_rx_present_o,
    output logic rx_idle_o,
    output logic lfps_o,
    output logic ss_rate_o,
    // Native AUX write of the display source
    output logic aux_wr_o,
    output logic [19:0] aux_addr_o,
    output logic [7:0] aux_data_o
);
    // Nothing attached, bus quiet
    initial begin
        far_rx_present_o = 1'h0;
        rx_idle_o = 1'h1;
        lfps_o = 1'h0;
        ss_rate_o = 1'h0;
        aux_wr_o = 1'h0;
        aux_addr_o = 20'h0;
        aux_data_o = 8'h0;
    end

    // New link conditions just after an edge
    task link(input logic pres, input logic idle, input logic lf, input logic rate);
        @(posedge clk_sys_i);
        far_rx_present_o <= pres;
        rx_idle_o <= idle;
        lfps_o <= lf;
        ss_rate_o <= rate;
    endtask

    // One-cycle write; the lines carry junk once it is over
    task aux_write(input logic [19:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i);
        aux_wr_o <= 1'h1;
        aux_addr_o <= addr;
        aux_data_o <= data;
        @(posedge clk_sys_i);
        aux_wr_o <= 1'h0;
        aux_addr_o <= ~addr;
        aux_data_o <= ~data;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_typec_dp_altmode_switch_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.vh"
module tb_typec_dp_altmode_switch_ctrl;
    localparam int DEB = 30;
    localparam int AUXO = 40;
    localparam int RXD = 50;
    localparam int HOLD = 20;
    localparam logic [19:0] LC = `TCS_DPCD_LANE_COUNT;
    localparam logic [19:0] PW = `TCS_DPCD_POWER;
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic usb_enable_pin_i = 1'h0, usb_enable_mid_i = 1'h0, display_enable_pin_i = 1'h0;
    logic flip_pin_i = 1'h0, hot_plug_input_i = 1'h0, snoop_disable_i = 1'h0;
    logic eq_override_i = 1'h0, flip_sel_i = 1'h0;
    logic [1:0] host_mode_strap_i = 2'h0, cfg_sel_i = 2'h1;
    logic [3:0] usb_down_eq_straps_i = 4'h9, usb_up_eq_straps_i = 4'h6;
    logic [3:0] display_eq_straps_i = 4'hc, dp_lane_en_reg_i = 4'h5;
    logic [3:0] usb_down_eq_field_a_i = 4'h3, usb_down_eq_field_b_i = 4'h7;
    logic [3:0] usb_up_eq_field_i = 4'ha, display_eq_field_i = 4'hb;
    wire aux_wr_i, far_rx_present_i, rx_idle_i, lfps_i, ss_rate_i;
    wire [19:0] aux_addr_i;
    wire [7:0] aux_data_i;
    wire device_active_o, pin_mode_o, strap_pulls_on_o, flip_o, rx_term_en_o, rx_detect_o;
    wire tx_idle_o, lfps_fwd_o, sstx_to_tx2_o, usb_path_en_o;
    wire [1:0] cfg_o, ssrx_src_o, aux_map_o;
    wire [3:0] usb_state_o, usb_down_eq_o, usb_up_eq_o, display_eq_o, dp_lane_en_o;
    wire [7:0] dp_route_o;
    logic [19:0] wa[6] = '{LC, LC, PW, PW, LC, LC};
    logic [7:0] wd[6] = '{8'h2, 8'h1, 8'h2, 8'h1, 8'h3, 8'h4};
    logic [7:0] we[6] = '{8'h3, 8'h1, 8'h0, 8'h1, 8'h0, 8'hf};
    int n_mismatch = 0;
    int checks_done = 0;
    int i;
    int n_det;

    // 20 MHz clock
    always #25 clk_sys_i = ~clk_sys_i;

    tcs_switch_ctrl #(.PWRUP_CYC(20), .RXDET_CYC(RXD), .SHTDN_CYC(20), .AUX_OPEN_CYC(AUXO),
        .DEBOUNCE_CYC(DEB), .U23_EXIT_CYC(200), .STRAP_HOLD_CYC(HOLD)) dut (
        .clk_sys_i, .rst_n_i, .usb_enable_pin_i, .usb_enable_mid_i, .display_enable_pin_i,
        .flip_pin_i, .hot_plug_input_i, .host_mode_strap_i, .usb_down_eq_straps_i,
        .usb_up_eq_straps_i, .display_eq_straps_i, .cfg_sel_i, .flip_sel_i, .snoop_disable_i,
        .dp_lane_en_reg_i, .eq_override_i, .usb_down_eq_field_a_i, .usb_down_eq_field_b_i,
        .usb_up_eq_field_i, .display_eq_field_i, .aux_wr_i, .aux_addr_i, .aux_data_i,
        .far_rx_present_i, .rx_idle_i, .lfps_i, .ss_rate_i, .device_active_o, .pin_mode_o,
        .strap_pulls_on_o, .cfg_o, .flip_o, .usb_state_o, .rx_term_en_o, .rx_detect_o,
        .tx_idle_o, .lfps_fwd_o, .usb_down_eq_o, .usb_up_eq_o, .display_eq_o, .dp_lane_en_o,
        .dp_route_o, .ssrx_src_o, .sstx_to_tx2_o, .usb_path_en_o, .aux_map_o);

    tcs_far_side far (.clk_sys_i, .far_rx_present_o(far_rx_present_i), .rx_idle_o(rx_idle_i),
        .lfps_o(lfps_i), .ss_rate_o(ss_rate_i), .aux_wr_o(aux_wr_i), .aux_addr_o(aux_addr_i),
        .aux_data_o(aux_data_i));

    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Wait, then sample once the edge has settled
    task step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task do_reset(input logic [1:0] host);
        @(posedge clk_sys_i);
        rst_n_i <= 1'h0;
        host_mode_strap_i <= host;
        step(3);
        @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        step(HOLD + 25);
    endtask

    // Enables overlap before the new setting takes over
    task pins(input logic d, input logic u, input logic f);
        @(posedge clk_sys_i);
        display_enable_pin_i <= display_enable_pin_i | d;
        usb_enable_pin_i <= usb_enable_pin_i | u;
        step(21);
        @(posedge clk_sys_i);
        display_enable_pin_i <= d;
        usb_enable_pin_i <= u;
        flip_pin_i <= f;
        step(DEB + AUXO + 8);
    endtask

    initial begin
        // Pin mode start-up, straps latched
        do_reset(2'h0);
        @(posedge clk_sys_i);
        usb_up_eq_straps_i <= 4'h1;
        step(2);
        chk(pin_mode_o, 8'h1);
        chk(strap_pulls_on_o, 8'h0);
        chk(device_active_o, 8'h1);
        chk(cfg_o, 8'h1);
        chk(usb_up_eq_o, 8'h6);
        chk(display_eq_o, 8'hc);
        chk(usb_down_eq_o, 8'h9);
        // Controller takes the device out of USB
        @(posedge clk_sys_i);
        usb_enable_pin_i <= 1'h1;
        step(3);
        @(posedge clk_sys_i);
        usb_enable_pin_i <= 1'h0;
        step(3);
        chk(cfg_o, 8'h0);
        @(posedge clk_sys_i);
        hot_plug_input_i <= 1'h1;
        // Every pin configuration with and without flip
        for (i = 0; i < 8; i++) begin
            pins(i[2], i[1], i[0]);
            chk(cfg_o, {6'h0, i[2:1]});
            chk(flip_o, {7'h0, i[0]});
            chk(aux_map_o, i[2] ? (i[0] ? 8'h2 : 8'h1) : 8'h0);
            chk(usb_path_en_o, {7'h0, i[1]});
            if (i[1]) chk({sstx_to_tx2_o, ssrx_src_o}, i[0] ? 8'h7 : 8'h1);
            if (i[2:1] == 2'h2) chk(dp_route_o, i[0] ? 8'hb4 : 8'h1e);
            if (i[2:1] == 2'h3) chk(dp_route_o[3:0], i[0] ? 8'h4 : 8'he);
            if (i[2:1] == 2'h2) chk(dp_lane_en_o, 8'hf);
            if (!i[2]) chk(dp_lane_en_o, 8'h0);
        end
        // Snoop ignored in pin mode, hot plug fall debounced
        pins(1'h1, 1'h0, 1'h0);
        far.aux_write(LC, 8'h1);
        step(4);
        chk(dp_lane_en_o, 8'hf);
        @(posedge clk_sys_i);
        hot_plug_input_i <= 1'h0;
        step(DEB / 2);
        chk(dp_lane_en_o, 8'hf);
        step(DEB);
        chk(dp_lane_en_o, 8'h0);
        // USB link up, idle, low frequency signalling, unplug
        pins(1'h0, 1'h1, 1'h0);
        chk(aux_map_o, 8'h0);
        far.link(1'h1, 1'h0, 1'h0, 1'h1);
        for (i = 0; i < 1000 && usb_state_o !== 4'h8; i++) step(1);
        chk(usb_state_o, 8'h8);
        if (i == 1000) final_report;
        chk(rx_term_en_o, 8'h1);
        far.link(1'h1, 1'h1, 1'h0, 1'h1);
        step(3);
        chk(tx_idle_o, 8'h1);
        far.link(1'h1, 1'h0, 1'h1, 1'h0);
        step(3);
        chk(usb_up_eq_o, 8'h0);
        chk(usb_down_eq_o, 8'h0);
        chk(lfps_fwd_o, 8'h1);
        far.link(1'h0, 1'h1, 1'h0, 1'h0);
        n_det = 0;
        for (i = 0; i < RXD * 3; i++) begin
            step(1);
            if (rx_detect_o === 1'h1) n_det++;
        end
        chk(usb_state_o, 8'h1);
        chk({7'h0, n_det >= 3}, 8'h1);
        // Shutdown exit through the mid-level usb enable
        pins(1'h0, 1'h0, 1'h0);
        far.link(1'h1, 1'h1, 1'h0, 1'h0);
        @(posedge clk_sys_i);
        usb_enable_mid_i <= 1'h1;
        step(10);
        chk(usb_state_o, 8'h0);
        step(15);
        chk(usb_state_o, 8'h2);
        // Register mode with snooped lane management
        @(posedge clk_sys_i);
        cfg_sel_i <= 2'h2;
        usb_enable_mid_i <= 1'h0;
        hot_plug_input_i <= 1'h1;
        do_reset(2'h3);
        chk(pin_mode_o, 8'h0);
        chk(dp_lane_en_o, 8'hf);
        for (i = 0; i < 6; i++) begin
            far.aux_write(wa[i], wd[i]);
            step(4);
            chk(dp_lane_en_o, we[i]);
        end
        @(posedge clk_sys_i);
        snoop_disable_i <= 1'h1;
        eq_override_i <= 1'h1;
        step(4);
        chk(dp_lane_en_o, 8'h5);
        chk(display_eq_o, 8'hb);
        chk(usb_up_eq_o, 8'ha);
        chk(usb_down_eq_o, 8'h3);
        chk(aux_map_o, 8'h1);
        final_report;
    end
endmodule
`default_nettype wire
